// File: cmp_ctrl.sv
// Comparator control: registers, mode decode, analog mux steering, change interrupt, pad drive
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cmp_ctrl (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [3:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  input  wire logic                 halt_i,
  input  wire logic                 cmp_raw_i,
  input  wire logic [15:0]          pin_cfg_word_i,
  input  wire logic                 first_pwm_channel_i,
  input  wire logic                 first_pwm_channel_en_i,
  output cmp_pkg::analog_sel_t      analog_sel_o,
  output logic      [15:0]          pad_analog_o,
  output logic                      port_b_pin3_o,
  output logic                      port_b_pin3_oe_n_o,
  output logic                      first_pwm_channel_block_o,
  output logic                      irq_o,
  output logic      [10:0]          irq_vector_o
);

  // ------------------------------------------------------------
  // Bus capture and register state
  // ------------------------------------------------------------
  cmp_pkg::bus_req_t req;
  logic [7:0]        analog_en_ff;
  logic [7:0]        cmp_ctrl_ff;
  logic              pad_oe_ff;
  logic              flag_ff;
  logic              irq_en_ff;
  logic              gie_ff;
  logic              sync1_ff;
  logic              sync2_ff;
  logic              copy_ff;
  logic              powered;
  logic [3:0]        ref_sel;
  logic [3:0]        pad_sel;
  cmp_pkg::cmp_mode_t mode;
  cmp_pkg::analog_sel_t nxt_sel;
  logic              mismatch;
  logic              flag_clr;
  logic              wr_osc;
  logic              clr_by_status;
  logic              clr_by_clear;
  logic [7:0]        nxt_rdata;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ------------------------------------------------------------
  // Synchroniser for the analog comparator output
  // ------------------------------------------------------------
  // The comparator settles with no relation to clk_i, so only sync2 is used
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= cmp_pkg::RST_BIT;
      sync2_ff <= cmp_pkg::RST_BIT;
    end else begin
      sync1_ff <= cmp_raw_i;
      sync2_ff <= sync1_ff;
    end
  end

  // ------------------------------------------------------------
  // Writable control registers
  // ------------------------------------------------------------
  assign wr_osc = req.wr && (req.addr == cmp_pkg::ADDR_OSC_CMP);

  // Enable register; bit 7 powers the comparator
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_en_ff <= cmp_pkg::RST_ANALOG_EN;
    end else if (req.wr && (req.addr == cmp_pkg::ADDR_ANALOG_EN)) begin
      analog_en_ff <= req.wdata;
    end
  end

  // Reference and pad select fields
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_ctrl_ff <= cmp_pkg::RST_CMP_CTRL;
    end else if (req.wr && (req.addr == cmp_pkg::ADDR_CMP_CTRL)) begin
      cmp_ctrl_ff <= req.wdata;
    end
  end

  // Pad output bit only; the result bit beside it is read-only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_oe_ff <= cmp_pkg::RST_BIT;
    end else if (wr_osc) begin
      pad_oe_ff <= req.wdata[cmp_pkg::BIT_PAD_OE];
    end
  end

  // Change interrupt enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_ff <= cmp_pkg::RST_BIT;
    end else if (req.wr && (req.addr == cmp_pkg::ADDR_IRQ_ENABLE)) begin
      irq_en_ff <= req.wdata[cmp_pkg::BIT_IRQ_FLAG];
    end
  end

  // Global interrupt enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gie_ff <= cmp_pkg::RST_BIT;
    end else if (req.wr && (req.addr == cmp_pkg::ADDR_GLOBAL_CTRL)) begin
      gie_ff <= req.wdata[cmp_pkg::BIT_GLOBAL_IE];
    end
  end

  // ------------------------------------------------------------
  // Mode and mux decode
  // ------------------------------------------------------------
  assign powered = analog_en_ff[cmp_pkg::BIT_CMP_ENABLE] && !halt_i;
  assign ref_sel = cmp_ctrl_ff[cmp_pkg::REF_SEL_LSB +: 4];
  assign pad_sel = cmp_ctrl_ff[cmp_pkg::PAD_SEL_LSB +: 4];
  assign mode    = (ref_sel == cmp_pkg::REF_PAD_TO_PAD) ? cmp_pkg::pad_to_pad_mode
                                                       : cmp_pkg::pad_to_reference_mode;

  // Steering word for the analog input multiplexers
  always_comb begin
    nxt_sel          = '0;
    nxt_sel.powered  = powered;
    case (mode)
      cmp_pkg::pad_to_reference_mode: begin
        nxt_sel.mode_ref   = 1'b1;
        nxt_sel.neg_is_ref = 1'b1;
        nxt_sel.ref_level  = ref_sel;
        nxt_sel.pos_pad    = pad_sel;
        nxt_sel.pos_valid  = (pad_sel != cmp_pkg::PAD_CODE_NONE);
      end
      cmp_pkg::pad_to_pad_mode: begin
        nxt_sel.pos_valid = 1'b1;
        // Cross-bank codes are not plain swaps of their neighbour, so spell all out
        case (pad_sel)
          // Port A low pair
          4'h0: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A0;
            nxt_sel.neg_pad = cmp_pkg::PAD_A1;
          end
          4'h1: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A1;
            nxt_sel.neg_pad = cmp_pkg::PAD_A0;
          end
          // Port A high pair
          4'h2: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A2;
            nxt_sel.neg_pad = cmp_pkg::PAD_A3;
          end
          4'h3: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A3;
            nxt_sel.neg_pad = cmp_pkg::PAD_A2;
          end
          // Port A against port B, low
          4'h4: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A0;
            nxt_sel.neg_pad = cmp_pkg::PAD_B3;
          end
          4'h5: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A1;
            nxt_sel.neg_pad = cmp_pkg::PAD_B2;
          end
          // Port A against port B, high
          4'h6: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A2;
            nxt_sel.neg_pad = cmp_pkg::PAD_B5;
          end
          4'h7: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_A3;
            nxt_sel.neg_pad = cmp_pkg::PAD_B4;
          end
          // Port B against port A, low
          4'h8: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B2;
            nxt_sel.neg_pad = cmp_pkg::PAD_A1;
          end
          4'h9: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B3;
            nxt_sel.neg_pad = cmp_pkg::PAD_A0;
          end
          // Port B against port A, high
          4'ha: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B4;
            nxt_sel.neg_pad = cmp_pkg::PAD_A3;
          end
          4'hb: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B5;
            nxt_sel.neg_pad = cmp_pkg::PAD_A2;
          end
          // Port B low pair
          4'hc: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B2;
            nxt_sel.neg_pad = cmp_pkg::PAD_B3;
          end
          4'hd: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B3;
            nxt_sel.neg_pad = cmp_pkg::PAD_B2;
          end
          // Port B high pair
          4'he: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B4;
            nxt_sel.neg_pad = cmp_pkg::PAD_B5;
          end
          4'hf: begin
            nxt_sel.pos_pad = cmp_pkg::PAD_B5;
            nxt_sel.neg_pad = cmp_pkg::PAD_B4;
          end
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  // Registered steering; the analog mux sees a glitch-free word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_sel_o <= '0;
      pad_analog_o <= 16'h0000;
    end else begin
      analog_sel_o <= nxt_sel;
      pad_analog_o <= pin_cfg_word_i;
    end
  end

  // ------------------------------------------------------------
  // Registered copy and change flag
  // ------------------------------------------------------------
  assign mismatch = (sync2_ff != copy_ff);
  // Status write of zero or clear write of one both drop the flag
  assign clr_by_status = req.wr && (req.addr == cmp_pkg::ADDR_IRQ_STATUS)
                         && !req.wdata[cmp_pkg::BIT_IRQ_FLAG];
  assign clr_by_clear  = req.wr && (req.addr == cmp_pkg::ADDR_IRQ_CLEAR)
                         && req.wdata[cmp_pkg::BIT_IRQ_FLAG];
  assign flag_clr      = clr_by_status || clr_by_clear;

  // Copy only moves on a read of ADDR_OSC_CMP, so a change stays pending until then
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      copy_ff <= cmp_pkg::RST_BIT;
    end else if (req.rd && (req.addr == cmp_pkg::ADDR_OSC_CMP)) begin
      copy_ff <= sync2_ff;
    end
  end

  // Set beats clear so a change in the clearing cycle is kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_ff <= cmp_pkg::RST_BIT;
    end else if (mismatch) begin
      flag_ff <= 1'b1;
    end else if (flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Interrupt, pad drive and PWM override
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= flag_ff && irq_en_ff && gie_ff;
    end
  end

  // Vector is fixed; held in a flop so the output comes straight from one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_vector_o <= cmp_pkg::IRQ_VECTOR;
    end else begin
      irq_vector_o <= cmp_pkg::IRQ_VECTOR;
    end
  end

  // One cycle latency after sync; pad follows result while enabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_b_pin3_o      <= 1'b0;
      port_b_pin3_oe_n_o <= 1'b1;
    end else if (pad_oe_ff) begin
      port_b_pin3_o      <= sync2_ff;
      port_b_pin3_oe_n_o <= 1'b0;
    end else begin
      port_b_pin3_o      <= first_pwm_channel_i;
      port_b_pin3_oe_n_o <= !first_pwm_channel_en_i;
    end
  end

  // PWM channel is told to stand aside while the pad carries the result
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_pwm_channel_block_o <= 1'b0;
    end else begin
      first_pwm_channel_block_o <= pad_oe_ff;
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  // Read mux; write-only and unmapped addresses read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        cmp_pkg::ADDR_ANALOG_EN:   nxt_rdata = analog_en_ff;
        cmp_pkg::ADDR_CMP_CTRL:    nxt_rdata = cmp_ctrl_ff;
        cmp_pkg::ADDR_OSC_CMP:     nxt_rdata = {sync2_ff, pad_oe_ff, 6'h00};
        cmp_pkg::ADDR_IRQ_STATUS:  nxt_rdata = {7'h00, flag_ff};
        cmp_pkg::ADDR_IRQ_ENABLE:  nxt_rdata = {7'h00, irq_en_ff};
        cmp_pkg::ADDR_GLOBAL_CTRL: nxt_rdata = {7'h00, gie_ff};
        default:                   nxt_rdata = 8'h00;
      endcase
    end
  end

  // Zero when idle, so the bus sees data in the answer cycle only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= nxt_rdata;
    end
  end

endmodule

// File: cmp_pkg.sv
// Package: register map, fields, reset values and carriers for the comparator control block
package cmp_pkg;

  // ------------------------------------------------------------
  // Register offsets (8-bit registers on the internal bus)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_ANALOG_EN   = 4'h0; // analog_enable_register
  localparam logic [3:0] ADDR_CMP_CTRL    = 4'h1; // comparator_control_register
  localparam logic [3:0] ADDR_OSC_CMP     = 4'h2; // osc_comparator_control_register
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h3; // sticky flags, read, write 0 clears
  localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h4; // per-flag interrupt enable
  localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'h5; // write 1 clears, reads zero
  localparam logic [3:0] ADDR_GLOBAL_CTRL = 4'h6; // global_irq_enable in bit 0

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_CMP_ENABLE   = 7; // comparator_enable_bit
  localparam int BIT_RESULT       = 7; // comparator_result_bit
  localparam int BIT_PAD_OE       = 6; // comparator_pad_output_enable
  localparam int BIT_IRQ_FLAG     = 0; // comparator_irq_flag
  localparam int BIT_GLOBAL_IE    = 0; // global_irq_enable
  localparam int REF_SEL_LSB      = 0; // reference_select_field [3:0]
  localparam int PAD_SEL_LSB      = 4; // pad_select_field [7:4]

  // ------------------------------------------------------------
  // Reset values and constants
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_ANALOG_EN  = 8'h00;
  localparam logic [7:0]  RST_CMP_CTRL   = 8'h00;
  localparam logic        RST_BIT        = 1'b0;
  localparam logic [3:0]  REF_PAD_TO_PAD = 4'h0;
  localparam logic [3:0]  PAD_CODE_NONE  = 4'h5;
  localparam logic [10:0] IRQ_VECTOR     = 11'h008;

  // Analog pad index space: 0..7 port A, 8..15 port B
  localparam logic [3:0]  PAD_A0 = 4'h0;
  localparam logic [3:0]  PAD_A1 = 4'h1;
  localparam logic [3:0]  PAD_A2 = 4'h2;
  localparam logic [3:0]  PAD_A3 = 4'h3;
  localparam logic [3:0]  PAD_B2 = 4'ha;
  localparam logic [3:0]  PAD_B3 = 4'hb;
  localparam logic [3:0]  PAD_B4 = 4'hc;
  localparam logic [3:0]  PAD_B5 = 4'hd;

  // Operating mode
  typedef enum logic {pad_to_pad_mode, pad_to_reference_mode} cmp_mode_t;

  // Analog mux steering sent to the analog macro
  typedef struct packed {
    logic        powered;      // Comparator bias on
    logic        mode_ref;     // 1 = pad_to_reference_mode
    logic        pos_valid;    // Non-inverting pad connected
    logic [3:0]  pos_pad;      // Non-inverting pad index
    logic        neg_is_ref;   // Inverting input taken from supply fraction
    logic [3:0]  neg_pad;      // Inverting pad index (pad-to-pad only)
    logic [3:0]  ref_level;    // n of n/16 supply fraction
  } analog_sel_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

endpackage

// File: cmp_ctrl_monitor.sv
// Port checker for the comparator control block
`timescale 1ns/1ps
module cmp_ctrl_monitor (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic [3:0]           addr_i,
  input wire logic [7:0]           wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [7:0]           rdata_o,
  input wire logic                 halt_i,
  input wire logic                 cmp_raw_i,
  input wire logic [15:0]          pin_cfg_word_i,
  input wire cmp_pkg::analog_sel_t analog_sel_o,
  input wire logic [15:0]          pad_analog_o,
  input wire logic                 port_b_pin3_o,
  input wire logic                 port_b_pin3_oe_n_o,
  input wire logic                 first_pwm_channel_block_o,
  input wire logic                 irq_o,
  input wire logic [10:0]          irq_vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_en_off;
    wr_i && addr_i == cmp_pkg::ADDR_ANALOG_EN && !wdata_i[7] |-> ##2 !analog_sel_o.powered;
  endproperty
  a_en_off: assert property (p_en_off) else $error("powered after disable");
  property p_halt; halt_i |=> !analog_sel_o.powered; endproperty
  a_halt: assert property (p_halt) else $error("powered in halt");
  property p_mode; analog_sel_o.mode_ref == (analog_sel_o.ref_level != 4'h0); endproperty
  a_mode: assert property (p_mode) else $error("mode and level disagree");
  property p_negref; analog_sel_o.neg_is_ref == analog_sel_o.mode_ref; endproperty
  a_negref: assert property (p_negref) else $error("reference on wrong input");
  // Guard skips the first edge, where outputs still hold reset values
  property p_p2p; !$past(rst_i) && !analog_sel_o.mode_ref |-> analog_sel_o.pos_valid; endproperty
  a_p2p: assert property (p_p2p) else $error("pad pair missing");
  property p_cfg; !$past(rst_i) |-> pad_analog_o == $past(pin_cfg_word_i); endproperty
  a_cfg: assert property (p_cfg) else $error("pad analog map stale");
  property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  // Two sync flops plus the pin register give three edges
  property p_pin;
    first_pwm_channel_block_o && $past(first_pwm_channel_block_o, 4) |-> port_b_pin3_o == $past(cmp_raw_i, 3);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not tracking result");
  property p_block; first_pwm_channel_block_o |-> !port_b_pin3_oe_n_o; endproperty
  a_block: assert property (p_block) else $error("pin not driven");
  property p_vec; irq_vector_o == cmp_pkg::IRQ_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  // Main scenarios reached
  c_irq: cover property ($rose(irq_o));
  c_halt: cover property ($fell(analog_sel_o.powered));
  c_pad: cover property (first_pwm_channel_block_o);
  c_none: cover property (analog_sel_o.mode_ref && !analog_sel_o.pos_valid);
endmodule
bind cmp_ctrl cmp_ctrl_monitor cmp_ctrl_monitor_i (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i), .cmp_raw_i(cmp_raw_i),
  .pin_cfg_word_i(pin_cfg_word_i), .analog_sel_o(analog_sel_o),
  .pad_analog_o(pad_analog_o), .port_b_pin3_o(port_b_pin3_o),
  .port_b_pin3_oe_n_o(port_b_pin3_oe_n_o), .first_pwm_channel_block_o(first_pwm_channel_block_o),
  .irq_o(irq_o), .irq_vector_o(irq_vector_o)
);

// File: testbench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module testbench;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic [3:0]           addr_i = 4'h0;
  logic [7:0]           wdata_i = 8'h00;
  logic                 wr_i = 1'b0, rd_i = 1'b0, halt_i = 1'b0, cmp_raw_i = 1'b0;
  logic [15:0]          pin_cfg_word_i = 16'h0000;
  logic                 first_pwm_channel_i = 1'b0, first_pwm_channel_en_i = 1'b0;
  logic [7:0]           rdata_o, d;
  cmp_pkg::analog_sel_t analog_sel_o;
  logic [15:0]          pad_analog_o;
  logic                 port_b_pin3_o, port_b_pin3_oe_n_o, first_pwm_channel_block_o, irq_o, f, cp;
  logic [10:0]          irq_vector_o;
  logic [31:0]          rnd = 32'h7aba;
  logic [3:0]           e;
  int                   num_errors = 0, total_checks = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  cmp_ctrl cmp_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i), .cmp_raw_i(cmp_raw_i),
    .pin_cfg_word_i(pin_cfg_word_i), .first_pwm_channel_i(first_pwm_channel_i), .first_pwm_channel_en_i(first_pwm_channel_en_i),
    .analog_sel_o(analog_sel_o), .pad_analog_o(pad_analog_o), .port_b_pin3_o(port_b_pin3_o),
    .port_b_pin3_oe_n_o(port_b_pin3_oe_n_o), .first_pwm_channel_block_o(first_pwm_channel_block_o), .irq_o(irq_o),
    .irq_vector_o(irq_vector_o));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Pad pairs: within a bank the odd code swaps its even partner's roles
  function automatic logic [7:0] pair(input logic [3:0] p);
    return {(p[3] ? 4'ha : 4'h0) + {2'h0, p[1:0]}, (p[2] ? 4'ha : 4'h0) + {2'h0, p[1], ~p[0]}};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Settle one time unit past the edge so its updates have landed
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic stir();
    rnd = lfsr(rnd);
    cmp_raw_i <= rnd[0]; first_pwm_channel_i <= rnd[1]; first_pwm_channel_en_i <= rnd[2]; pin_cfg_word_i <= rnd[31:16];
    tk(5);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far above the fewer than 1500 cycles used
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 10000) begin num_errors++; print_verdict(); end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(4'hf, 8'hff);
    for (int a = 0; a < 16; a++) begin rd(a[3:0]); chk(d, 8'h00); end
    chk(analog_sel_o.powered, 1'b0);
    wr(cmp_pkg::ADDR_ANALOG_EN, 8'h80); tk(2);
    chk(analog_sel_o.powered, 1'b1);
    halt_i <= 1'b1; tk(2);
    chk(analog_sel_o.powered, 1'b0);
    halt_i <= 1'b0; tk(2);
    chk(analog_sel_o.powered, 1'b1);
    // Every reference code against every pad code
    for (int c = 0; c < 256; c++) begin
      e = c[3:0];
      wr(cmp_pkg::ADDR_CMP_CTRL, c[7:0]); tk(2);
      chk(analog_sel_o.mode_ref, e != 4'h0);
      chk(analog_sel_o.neg_is_ref, e != 4'h0);
      if (e != 4'h0) begin
        chk({analog_sel_o.ref_level, analog_sel_o.pos_valid}, {e, c[7:4] != 4'h5});
        if (c[7:4] != 4'h5) chk(analog_sel_o.pos_pad, c[7:4]);
      end else chk({analog_sel_o.pos_pad, analog_sel_o.neg_pad}, pair(c[7:4]));
    end
    // Arm in the documented order, then random result changes
    wr(cmp_pkg::ADDR_IRQ_ENABLE, 8'h01); wr(cmp_pkg::ADDR_GLOBAL_CTRL, 8'h01);
    rd(cmp_pkg::ADDR_OSC_CMP); wr(cmp_pkg::ADDR_IRQ_STATUS, 8'h00); tk(3);
    chk(irq_o, 1'b0);
    f = 1'b0; cp = 1'b0;
    for (int i = 0; i < 24; i++) begin
      stir(); f = f | (cmp_raw_i != cp);
      chk(pad_analog_o, pin_cfg_word_i);
      chk(irq_o, f);
      rd(cmp_pkg::ADDR_IRQ_STATUS); chk(d, {7'h0, f});
      if (rnd[3]) begin rd(cmp_pkg::ADDR_OSC_CMP); chk(d, {cmp_raw_i, 7'h0}); cp = cmp_raw_i; end
      if (rnd[4]) begin wr(cmp_pkg::ADDR_IRQ_STATUS, 8'h00); f = cmp_raw_i != cp; end
    end
    // Masking, clear register and the set-wins case
    rd(cmp_pkg::ADDR_OSC_CMP); wr(cmp_pkg::ADDR_IRQ_CLEAR, 8'h01);
    wr(cmp_pkg::ADDR_IRQ_ENABLE, 8'h00); cmp_raw_i <= ~cmp_raw_i; tk(5);
    chk(irq_o, 1'b0);
    wr(cmp_pkg::ADDR_IRQ_CLEAR, 8'h01); rd(cmp_pkg::ADDR_IRQ_STATUS); chk(d, 8'h01);
    rd(cmp_pkg::ADDR_OSC_CMP); wr(cmp_pkg::ADDR_IRQ_CLEAR, 8'h01);
    rd(cmp_pkg::ADDR_IRQ_STATUS); chk(d, 8'h00);
    rd(cmp_pkg::ADDR_IRQ_CLEAR); chk(d, 8'h00);
    wr(cmp_pkg::ADDR_IRQ_ENABLE, 8'h01); wr(cmp_pkg::ADDR_GLOBAL_CTRL, 8'h00);
    cmp_raw_i <= ~cmp_raw_i; tk(5);
    chk(irq_o, 1'b0);
    wr(cmp_pkg::ADDR_GLOBAL_CTRL, 8'h01); tk(3);
    chk({irq_o, irq_vector_o}, {1'b1, 11'h008});
    // Result driven onto the pad over the PWM channel
    wr(cmp_pkg::ADDR_OSC_CMP, 8'h40);
    for (int i = 0; i < 8; i++) begin
      stir();
      chk({port_b_pin3_o, port_b_pin3_oe_n_o}, {cmp_raw_i, 1'b0});
      chk(first_pwm_channel_block_o, 1'b1);
      rd(cmp_pkg::ADDR_OSC_CMP); chk(d, {cmp_raw_i, 7'h40});
    end
    wr(cmp_pkg::ADDR_OSC_CMP, 8'h00); tk(3);
    chk(first_pwm_channel_block_o, 1'b0);
    chk({port_b_pin3_o, port_b_pin3_oe_n_o}, {first_pwm_channel_i, ~first_pwm_channel_en_i});
    // Second reset in mid-run brings the enable back to zero
    rst_i <= 1'b1; tk(2);
    rst_i <= 1'b0; rd(cmp_pkg::ADDR_ANALOG_EN); chk(d, 8'h00);
    print_verdict();
  end
endmodule
